// File: hw/msprg_pkg.sv
// Functional notes
// - drive motor toward target position in position modes
// - preset register holds signed 32-bit value
// - control bit 8 selects relative or absolute preset
// - control bit 6 updates actual and target atomically
// - preset also adjusts profile position, no movement
// - fast commands 23 and 24 perform presets
// - velocity setpoint in counts/sample, default 277
// - acceleration setpoint in counts/sample squared, default 18
// - torque limit 0..1023 caps torque, default 1023
// - zero search loads zero-point encoder position
// - actual position refreshed every 1.3 or 2.6 ms
// - actual position incremental, software writable offset
// - zero search completion overwrites actual position
// - averaged velocity read-only, over 16 samples
// - instant velocity read-only, counts per sample
// - load inertia ratio 16.16, default 1.0
// - mode 0 is passive, axis not controlled
package msprg_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LOOP_PERIOD_US = 1300;
  localparam int unsigned LOOP_CYCLES = (LOOP_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam logic [31:0] OUTDIV_DOUBLE = 32'h2;
  localparam int unsigned AVG_SAMPLES = 16;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'h02;
  localparam logic [7:0] IDX_TARGET = 8'h03;
  localparam logic [7:0] IDX_PRESET = 8'h04;
  localparam logic [7:0] IDX_VELOCITY = 8'h05;
  localparam logic [7:0] IDX_ACCEL = 8'h06;
  localparam logic [7:0] IDX_TORQUE = 8'h07;
  localparam logic [7:0] IDX_PROFILE = 8'h08;
  localparam logic [7:0] IDX_ZERO_OFS = 8'h09;
  localparam logic [7:0] IDX_ACTUAL = 8'h0a;
  localparam logic [7:0] IDX_AVG_VEL = 8'h0b;
  localparam logic [7:0] IDX_INST_VEL = 8'h0c;
  localparam logic [7:0] IDX_LOAD = 8'h0d;
  localparam logic [7:0] IDX_CONTROL = 8'h24;
  localparam logic [7:0] IDX_OUTDIV = 8'h9d;
  // reset values
  localparam logic [31:0] RST_VELOCITY = 32'h115;
  localparam logic [31:0] RST_ACCEL = 32'h12;
  localparam logic [9:0] RST_TORQUE = 10'h3ff;
  localparam logic [31:0] RST_LOAD = 32'h10000;
  localparam logic [31:0] RST_OUTDIV = 32'h1;
  localparam logic [31:0] MODE_PASSIVE = 32'h0;
  // torque limit ceiling and nominal point
  localparam logic [9:0] TORQUE_MAX = 10'h3ff;
  localparam logic [9:0] TORQUE_NOMINAL = 10'h155;
  // control flag bit positions
  localparam int unsigned CTRL_EXEC_BIT = 6;
  localparam int unsigned CTRL_REL_BIT = 8;
  // fast command codes
  localparam logic [7:0] FAST_CMD_ABS = 8'h17;
  localparam logic [7:0] FAST_CMD_REL = 8'h18;
endpackage

// File: hw/msprg_regs.sv
`timescale 1ns/10ps
module msprg_regs #(
  parameter int unsigned LOOP_CYCLES = msprg_pkg::LOOP_CYCLES,
  parameter int unsigned AVG_SAMPLES = msprg_pkg::AVG_SAMPLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // encoder counter, same clock domain
  input wire logic [31:0] enc_count_i,
  // fast command strobe
  input wire logic fast_cmd_valid_i,
  input wire logic [7:0] fast_cmd_i,
  // zero search result strobe
  input wire logic zero_done_i,
  input wire logic [31:0] zero_enc_pos_i,
  input wire logic [31:0] zero_position_i,
  // setpoints toward the control loops
  output logic drive_active_o,
  output logic [31:0] position_error_o,
  output logic [31:0] velocity_limit_o,
  output logic [31:0] accel_limit_o,
  output logic [9:0] torque_cap_o,
  output logic [31:0] load_ratio_o,
  output logic sample_tick_o
);

  localparam int unsigned HW = $clog2(AVG_SAMPLES);

  // refuse sizes the logic cannot serve, before any cycle runs
  if (LOOP_CYCLES < 2 || AVG_SAMPLES < 2 ||
      (AVG_SAMPLES & (AVG_SAMPLES - 1)) != 0) begin : g_bad_size
    $error("msprg_regs: bad LOOP_CYCLES or AVG_SAMPLES");
  end

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] mode;
    logic [31:0] target;
    logic [31:0] preset;
    logic [31:0] velocity;
    logic [31:0] accel;
    logic [9:0] torque;
    logic [31:0] profile;
    logic [31:0] zero_ofs;
    logic [31:0] actual;
    logic [31:0] avg_vel;
    logic [31:0] inst_vel;
    logic [31:0] load_ratio;
    logic exec;
    logic rel;
    logic [31:0] outdiv;
    logic [31:0] tick_cnt;
    logic [31:0] last_enc;
    logic [AVG_SAMPLES-1:0][31:0] hist;
    logic [HW-1:0] hist_idx;
    logic tick;
    logic [31:0] perr;
    logic drive_active;
  } msprg_state_t;

  msprg_state_t s;
  msprg_state_t next_s;

  // byte-lane merge of a write
  function automatic logic [31:0] msprg_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // saturate a torque request into the 10-bit range
  function automatic logic [9:0] msprg_clamp(input logic [31:0] v);
    if (v > {22'h0, msprg_pkg::TORQUE_MAX}) begin
      return msprg_pkg::TORQUE_MAX;
    end
    return v[9:0];
  endfunction

  // bus decode
  logic bus_req;
  logic wr;
  logic [7:0] idx;
  logic [31:0] wdata_act;
  assign bus_req = wb_cyc_i & wb_stb_i & ~s.ack;
  assign wr = bus_req & wb_we_i;
  assign idx = wb_adr_i[9:2];
  assign wdata_act = msprg_merge(s.actual, wb_dat_i, wb_sel_i);

  // loop period: doubled when the outer-loop divider is 2
  logic [31:0] tick_limit;
  logic tick_now;
  logic [31:0] delta;
  logic [31:0] acc;
  assign tick_limit = (s.outdiv == msprg_pkg::OUTDIV_DOUBLE) ? 32'(2 * LOOP_CYCLES)
                                                            : 32'(LOOP_CYCLES);
  // at or past the end, so a divider that shortens the period cannot skip it
  assign tick_now = (s.tick_cnt >= tick_limit - 32'h1);
  assign delta = enc_count_i - s.last_enc;
  assign acc = tick_now ? delta : 32'h0;

  // next state
  always_comb begin
    logic [31:0] base;
    base = s.actual;
    next_s = s;
    next_s.ack = bus_req;
    next_s.rdata = 32'h0;
    next_s.tick = tick_now;
    // sample tick and incremental encoder accumulation
    next_s.tick_cnt = tick_now ? 32'h0 : s.tick_cnt + 32'h1;
    if (tick_now) begin
      next_s.last_enc = enc_count_i;
      next_s.inst_vel = delta;
      // running sum over the window avoids a 16-way adder
      next_s.avg_vel = s.avg_vel - s.hist[s.hist_idx] + delta;
      next_s.hist[s.hist_idx] = delta;
      next_s.hist_idx = s.hist_idx + 1'b1;
    end
    // atomic preset: actual, target and profile move together
    if (s.exec) begin
      if (s.rel) begin
        base = s.actual + s.preset;
        next_s.target = s.target + s.preset;
        next_s.profile = s.profile + s.preset;
      end else begin
        base = s.preset;
        next_s.target = s.preset;
        next_s.profile = s.preset;
      end
      next_s.exec = 1'b0;
    end
    // zero search result
    if (zero_done_i) begin
      base = zero_position_i;
      next_s.zero_ofs = zero_enc_pos_i;
    end
    // fast commands set the same control flags
    if (fast_cmd_valid_i && fast_cmd_i == msprg_pkg::FAST_CMD_ABS) begin
      next_s.rel = 1'b0;
      next_s.exec = 1'b1;
    end
    if (fast_cmd_valid_i && fast_cmd_i == msprg_pkg::FAST_CMD_REL) begin
      next_s.rel = 1'b1;
      next_s.exec = 1'b1;
    end
    // register writes; a set of the execute bit wins over its clear
    if (wr) begin
      unique case (idx)
        msprg_pkg::IDX_MODE: next_s.mode = msprg_merge(s.mode, wb_dat_i, wb_sel_i);
        msprg_pkg::IDX_TARGET: next_s.target = msprg_merge(s.target, wb_dat_i, wb_sel_i);
        msprg_pkg::IDX_PRESET: next_s.preset = msprg_merge(s.preset, wb_dat_i, wb_sel_i);
        msprg_pkg::IDX_VELOCITY: next_s.velocity = msprg_merge(s.velocity, wb_dat_i, wb_sel_i);
        msprg_pkg::IDX_ACCEL: next_s.accel = msprg_merge(s.accel, wb_dat_i, wb_sel_i);
        msprg_pkg::IDX_TORQUE: begin
          next_s.torque = msprg_clamp(msprg_merge({22'h0, s.torque}, wb_dat_i, wb_sel_i));
        end
        msprg_pkg::IDX_PROFILE: next_s.profile = msprg_merge(s.profile, wb_dat_i, wb_sel_i);
        msprg_pkg::IDX_ZERO_OFS: next_s.zero_ofs = msprg_merge(s.zero_ofs, wb_dat_i, wb_sel_i);
        msprg_pkg::IDX_ACTUAL: base = wdata_act;
        msprg_pkg::IDX_LOAD: next_s.load_ratio = msprg_merge(s.load_ratio, wb_dat_i, wb_sel_i);
        msprg_pkg::IDX_CONTROL: begin
          if (wb_sel_i[1]) begin
            next_s.rel = wb_dat_i[msprg_pkg::CTRL_REL_BIT];
          end
          if (wb_sel_i[0] && wb_dat_i[msprg_pkg::CTRL_EXEC_BIT]) begin
            next_s.exec = 1'b1;
          end
        end
        msprg_pkg::IDX_OUTDIV: next_s.outdiv = msprg_merge(s.outdiv, wb_dat_i, wb_sel_i);
        default: ; // read-only or unmapped: write ignored
      endcase
    end
    // encoder increments always land on top of whichever base won
    next_s.actual = base + acc;
    // read mux; unmapped reads return zero
    if (bus_req && !wb_we_i) begin
      unique case (idx)
        msprg_pkg::IDX_MODE: next_s.rdata = s.mode;
        msprg_pkg::IDX_TARGET: next_s.rdata = s.target;
        msprg_pkg::IDX_PRESET: next_s.rdata = s.preset;
        msprg_pkg::IDX_VELOCITY: next_s.rdata = s.velocity;
        msprg_pkg::IDX_ACCEL: next_s.rdata = s.accel;
        msprg_pkg::IDX_TORQUE: next_s.rdata = {22'h0, s.torque};
        msprg_pkg::IDX_PROFILE: next_s.rdata = s.profile;
        msprg_pkg::IDX_ZERO_OFS: next_s.rdata = s.zero_ofs;
        msprg_pkg::IDX_ACTUAL: next_s.rdata = s.actual;
        msprg_pkg::IDX_AVG_VEL: next_s.rdata = s.avg_vel;
        msprg_pkg::IDX_INST_VEL: next_s.rdata = s.inst_vel;
        msprg_pkg::IDX_LOAD: next_s.rdata = s.load_ratio;
        msprg_pkg::IDX_CONTROL: begin
          next_s.rdata[msprg_pkg::CTRL_EXEC_BIT] = s.exec;
          next_s.rdata[msprg_pkg::CTRL_REL_BIT] = s.rel;
        end
        msprg_pkg::IDX_OUTDIV: next_s.rdata = s.outdiv;
        default: next_s.rdata = 32'h0;
      endcase
    end
    // loop demand: error toward target, none while passive
    next_s.drive_active = (next_s.mode != msprg_pkg::MODE_PASSIVE);
    next_s.perr = next_s.drive_active ? next_s.target - next_s.actual : 32'h0;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.velocity <= msprg_pkg::RST_VELOCITY;
      s.accel <= msprg_pkg::RST_ACCEL;
      s.torque <= msprg_pkg::RST_TORQUE;
      s.load_ratio <= msprg_pkg::RST_LOAD;
      s.outdiv <= msprg_pkg::RST_OUTDIV;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdata;
  assign drive_active_o = s.drive_active;
  assign position_error_o = s.perr;
  assign velocity_limit_o = s.velocity;
  assign accel_limit_o = s.accel;
  assign torque_cap_o = s.torque;
  assign load_ratio_o = s.load_ratio;
  assign sample_tick_o = s.tick;

  // helper: cycles between ticks, restarted when the divider changes
  logic [31:0] chk_gap;
  logic chk_seen;
  always_ff @(posedge clk_i) begin
    if (rst_i || s.tick || s.outdiv != next_s.outdiv) begin
      chk_gap <= 32'h1;
      chk_seen <= ~rst_i & s.tick & (s.outdiv == next_s.outdiv);
    end else begin
      chk_gap <= chk_gap + 32'h1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // sample tick: one pulse per loop period, measured between whole periods
  chk_tick_period: assert property (s.tick && chk_seen |-> chk_gap == tick_limit)
    else $error("sample tick period wrong");
  chk_tick_pulse: assert property (s.tick |=> !s.tick)
    else $error("sample tick wider than one cycle");

  // atomic preset: actual, target and profile move at one edge
  chk_preset_abs: assert property (s.exec && !s.rel && !wr |=>
    s.target == $past(s.preset) && s.profile == $past(s.preset))
    else $error("absolute preset not applied");
  chk_preset_rel: assert property (s.exec && s.rel && !wr |=>
    s.target == $past(s.target) + $past(s.preset))
    else $error("relative preset not added");
  chk_preset_actual: assert property (s.exec && !s.rel && !wr && !zero_done_i |=>
    s.actual == $past(s.preset) + $past(acc))
    else $error("actual position not preset");
  chk_rel_actual: assert property (s.exec && s.rel && !wr && !zero_done_i |=>
    s.actual == $past(s.actual) + $past(s.preset) + $past(acc))
    else $error("actual position not offset");
  chk_rel_profile: assert property (s.exec && s.rel && !wr |=>
    s.profile == $past(s.profile) + $past(s.preset))
    else $error("profile position not offset");
  // a relative preset while driving must not change the demand, or the axis jumps
  chk_preset_still: assert property (s.exec && s.rel && s.drive_active && !wr
    && !zero_done_i && !tick_now |=> s.perr == $past(s.perr))
    else $error("preset moved the position error");

  // control flags: a write sets, the applied preset clears
  chk_exec_set: assert property (wr && idx == msprg_pkg::IDX_CONTROL && wb_sel_i[0]
    && wb_dat_i[msprg_pkg::CTRL_EXEC_BIT] |=> s.exec)
    else $error("execute bit not set");
  chk_exec_clears: assert property (s.exec && !wr && !fast_cmd_valid_i |=> !s.exec)
    else $error("execute bit did not clear");
  chk_rel_select: assert property (wr && idx == msprg_pkg::IDX_CONTROL && wb_sel_i[1]
    && !fast_cmd_valid_i |=> s.rel == $past(wb_dat_i[msprg_pkg::CTRL_REL_BIT]))
    else $error("relative select not stored");
  chk_preset_write: assert property (wr && idx == msprg_pkg::IDX_PRESET
    && wb_sel_i == 4'hf |=> s.preset == $past(wb_dat_i))
    else $error("preset value not stored");

  // fast commands raise the same flags as a control write
  chk_fast_abs: assert property (fast_cmd_valid_i
    && fast_cmd_i == msprg_pkg::FAST_CMD_ABS && !wr |=> s.exec && !s.rel ##1 !s.exec)
    else $error("absolute fast command not executed");
  chk_fast_rel: assert property (fast_cmd_valid_i
    && fast_cmd_i == msprg_pkg::FAST_CMD_REL && !wr |=> s.exec && s.rel ##1 !s.exec)
    else $error("relative fast command not executed");

  // setpoints reach the loop outputs one edge after the write
  chk_velocity_out: assert property (wr && idx == msprg_pkg::IDX_VELOCITY
    && wb_sel_i == 4'hf |=> velocity_limit_o == $past(wb_dat_i))
    else $error("velocity setpoint not passed on");
  chk_accel_out: assert property (wr && idx == msprg_pkg::IDX_ACCEL
    && wb_sel_i == 4'hf |=> accel_limit_o == $past(wb_dat_i))
    else $error("acceleration setpoint not passed on");
  chk_load_out: assert property (wr && idx == msprg_pkg::IDX_LOAD
    && wb_sel_i == 4'hf |=> load_ratio_o == $past(wb_dat_i))
    else $error("load ratio not passed on");
  chk_torque_sat: assert property (wr && idx == msprg_pkg::IDX_TORQUE
    && wb_sel_i == 4'hf && wb_dat_i > {22'h0, msprg_pkg::TORQUE_MAX}
    |=> s.torque == msprg_pkg::TORQUE_MAX)
    else $error("torque limit not saturated");
  chk_torque_pass: assert property (wr && idx == msprg_pkg::IDX_TORQUE
    && wb_sel_i == 4'hf && wb_dat_i <= {22'h0, msprg_pkg::TORQUE_MAX}
    |=> torque_cap_o == $past(wb_dat_i[9:0]))
    else $error("torque limit not taken");

  // zero search result overwrites offset and actual position
  chk_zero_offset: assert property (zero_done_i
    && !(wr && idx == msprg_pkg::IDX_ZERO_OFS) |=> s.zero_ofs == $past(zero_enc_pos_i))
    else $error("zero offset not loaded");
  chk_zero_actual: assert property (zero_done_i
    && !(wr && idx == msprg_pkg::IDX_ACTUAL)
    |=> s.actual == $past(zero_position_i) + $past(acc))
    else $error("zero search position not loaded");

  // encoder increments and the software offset of the actual position
  chk_enc_accum: assert property (tick_now && !s.exec && !zero_done_i && !wr
    |=> s.actual == $past(s.actual) + $past(delta))
    else $error("encoder increment lost");
  chk_actual_write: assert property (wr && idx == msprg_pkg::IDX_ACTUAL
    && wb_sel_i == 4'hf |=> s.actual == $past(wb_dat_i) + $past(acc))
    else $error("actual position write lost");

  // velocities: refreshed on the tick only, never by a write
  chk_inst_vel: assert property (tick_now
    |=> s.inst_vel == $past(delta) ##1 $stable(s.inst_vel))
    else $error("instant velocity wrong");
  chk_inst_ro: assert property (wr && idx == msprg_pkg::IDX_INST_VEL && !tick_now
    |=> $stable(s.inst_vel))
    else $error("instant velocity written");
  chk_avg_window: assert property (tick_now |=>
    s.avg_vel == $past(s.avg_vel) - $past(s.hist[s.hist_idx]) + $past(delta))
    else $error("averaged velocity wrong");
  chk_avg_ro: assert property (wr && idx == msprg_pkg::IDX_AVG_VEL && !tick_now
    |=> $stable(s.avg_vel))
    else $error("averaged velocity written");

  // demand toward the loops: none while passive, else target minus actual
  chk_passive_idle: assert property (s.mode == msprg_pkg::MODE_PASSIVE && !wr
    |=> !s.drive_active && s.perr == 32'h0)
    else $error("passive mode still drives");
  chk_active_mode: assert property (s.drive_active
    == (s.mode != msprg_pkg::MODE_PASSIVE))
    else $error("drive active does not follow the mode");
  chk_error_value: assert property (s.drive_active
    |-> position_error_o == s.target - s.actual)
    else $error("position error not target minus actual");

  // bus: one ack per request, data only alongside it
  chk_bus_ack: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack timing wrong");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");

endmodule

// File: testbench/msprg_regs_tb.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module msprg_regs_tb;
  localparam int unsigned LOOP = 20;
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [9:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, enc_count_i, zero_enc_pos_i, zero_position_i;
  logic [3:0] wb_sel_i;
  logic fast_cmd_valid_i, zero_done_i, drive_active_o, sample_tick_o;
  logic [7:0] fast_cmd_i;
  logic [31:0] position_error_o, velocity_limit_o, accel_limit_o, load_ratio_o;
  logic [9:0] torque_cap_o;
  logic [31:0] rd;
  logic [3:0] lanes;
  int errors, tests_run, n;

  msprg_regs #(.LOOP_CYCLES(LOOP), .AVG_SAMPLES(16)) i_msprg_regs (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .enc_count_i(enc_count_i), .fast_cmd_valid_i(fast_cmd_valid_i), .fast_cmd_i(fast_cmd_i),
    .zero_done_i(zero_done_i), .zero_enc_pos_i(zero_enc_pos_i),
    .zero_position_i(zero_position_i), .drive_active_o(drive_active_o),
    .position_error_o(position_error_o), .velocity_limit_o(velocity_limit_o),
    .accel_limit_o(accel_limit_o), .torque_cap_o(torque_cap_o),
    .load_ratio_o(load_ratio_o), .sample_tick_o(sample_tick_o));

  // free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic stop_test;
    $display("errors %0d comparisons %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= lanes;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      errors++;
      stop_test();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input string nm);
    wb(1'b0, idx, 32'h0);
    `CHK(nm, exp, rd)
  endtask

  // one-cycle strobe: fast command when f is set, zero search done otherwise
  task automatic strobe(input logic f, input logic [7:0] c);
    @(posedge clk_i);
    fast_cmd_valid_i <= f;
    zero_done_i <= ~f;
    fast_cmd_i <= c;
    @(posedge clk_i);
    fast_cmd_valid_i <= 1'b0;
    zero_done_i <= 1'b0;
  endtask

  // n counts the edges of this call; called back to back it is one period
  task automatic wait_tick;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (sample_tick_o !== 1'b1 && n < 100);
    if (n >= 100) begin
      errors++;
      stop_test();
    end
  endtask

  initial begin
    errors = 0;
    tests_run = 0;
    rst_i = 1'b1;
    {wb_we_i, wb_cyc_i, wb_stb_i, fast_cmd_valid_i, zero_done_i} = 5'h0;
    wb_adr_i = 10'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hf;
    lanes = 4'hf;
    fast_cmd_i = 8'h0;
    enc_count_i = 32'h0;
    zero_enc_pos_i = 32'h0;
    zero_position_i = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values; encoder held still so ticks add nothing yet
    rchk(msprg_pkg::IDX_VELOCITY, 32'h115, "velocity");
    rchk(msprg_pkg::IDX_ACCEL, 32'h12, "accel");
    rchk(msprg_pkg::IDX_TORQUE, 32'h3ff, "torque");
    rchk(msprg_pkg::IDX_LOAD, 32'h10000, "load");
    rchk(msprg_pkg::IDX_PRESET, 32'h0, "preset");
    rchk(msprg_pkg::IDX_ACTUAL, 32'h0, "actual");
    rchk(msprg_pkg::IDX_AVG_VEL, 32'h0, "avg vel");
    rchk(msprg_pkg::IDX_INST_VEL, 32'h0, "inst vel");
    rchk(8'h01, 32'h0, "unmapped");
    // torque saturates at the peak, nominal passes through
    wb(1'b1, msprg_pkg::IDX_TORQUE, 32'h400);
    rchk(msprg_pkg::IDX_TORQUE, 32'h3ff, "torque sat");
    wb(1'b1, msprg_pkg::IDX_TORQUE, 32'h155);
    `CHK("torque cap", 10'h155, torque_cap_o)
    wb(1'b1, msprg_pkg::IDX_VELOCITY, 32'h22a);
    `CHK("vel limit", 32'h22a, velocity_limit_o)
    wb(1'b1, msprg_pkg::IDX_ACCEL, 32'h168);
    `CHK("accel limit", 32'h168, accel_limit_o)
    wb(1'b1, msprg_pkg::IDX_LOAD, 32'h18000);
    `CHK("load out", 32'h18000, load_ratio_o)
    // read-only velocities ignore writes
    wb(1'b1, msprg_pkg::IDX_AVG_VEL, 32'h1234);
    rchk(msprg_pkg::IDX_AVG_VEL, 32'h0, "avg ro");
    wb(1'b1, msprg_pkg::IDX_INST_VEL, 32'h1234);
    rchk(msprg_pkg::IDX_INST_VEL, 32'h0, "inst ro");
    // absolute preset, then negative relative preset
    wb(1'b1, msprg_pkg::IDX_TARGET, 32'h55);
    wb(1'b1, msprg_pkg::IDX_PRESET, 32'h100);
    wb(1'b1, msprg_pkg::IDX_CONTROL, 32'h40);
    rchk(msprg_pkg::IDX_TARGET, 32'h100, "abs target");
    rchk(msprg_pkg::IDX_ACTUAL, 32'h100, "abs actual");
    rchk(msprg_pkg::IDX_PROFILE, 32'h100, "abs profile");
    wb(1'b0, msprg_pkg::IDX_CONTROL, 32'h0);
    `CHK("exec bit", 1'b0, rd[6])
    wb(1'b1, msprg_pkg::IDX_PRESET, 32'hfffffe00);
    wb(1'b1, msprg_pkg::IDX_CONTROL, 32'h140);
    rchk(msprg_pkg::IDX_TARGET, 32'hffffff00, "rel target");
    rchk(msprg_pkg::IDX_ACTUAL, 32'hffffff00, "rel actual");
    rchk(msprg_pkg::IDX_PROFILE, 32'hffffff00, "rel profile");
    // fast commands, plus a code that must be ignored
    wb(1'b1, msprg_pkg::IDX_PRESET, 32'h10);
    strobe(1'b1, msprg_pkg::FAST_CMD_ABS);
    rchk(msprg_pkg::IDX_ACTUAL, 32'h10, "fast abs");
    strobe(1'b1, msprg_pkg::FAST_CMD_REL);
    rchk(msprg_pkg::IDX_TARGET, 32'h20, "fast rel");
    strobe(1'b1, 8'h19);
    rchk(msprg_pkg::IDX_ACTUAL, 32'h20, "fast other");
    // byte enables merge only the selected lane
    lanes = 4'h2;
    wb(1'b1, msprg_pkg::IDX_PRESET, 32'hffffabff);
    lanes = 4'hf;
    rchk(msprg_pkg::IDX_PRESET, 32'h0000ab10, "preset lane");
    // passive versus active, and a preset while active keeps the error
    wb(1'b1, msprg_pkg::IDX_TARGET, 32'h50);
    `CHK("passive err", 32'h0, position_error_o)
    `CHK("passive", 1'b0, drive_active_o)
    wb(1'b1, msprg_pkg::IDX_MODE, 32'h2);
    `CHK("active", 1'b1, drive_active_o)
    `CHK("active err", 32'h30, position_error_o)
    wb(1'b1, msprg_pkg::IDX_PRESET, 32'h40);
    wb(1'b1, msprg_pkg::IDX_CONTROL, 32'h140);
    rchk(msprg_pkg::IDX_TARGET, 32'h90, "active target");
    `CHK("preset err", 32'h30, position_error_o)
    wb(1'b1, msprg_pkg::IDX_MODE, 32'h0);
    // zero search result
    zero_enc_pos_i <= 32'h77;
    zero_position_i <= 32'h1234;
    strobe(1'b0, 8'h0);
    rchk(msprg_pkg::IDX_ZERO_OFS, 32'h77, "zero ofs");
    rchk(msprg_pkg::IDX_ACTUAL, 32'h1234, "zero actual");
    // software offset, then encoder increments accumulate on top
    wb(1'b1, msprg_pkg::IDX_ACTUAL, 32'h1000);
    wait_tick();
    enc_count_i <= 32'h5;
    wait_tick();
    rchk(msprg_pkg::IDX_ACTUAL, 32'h1005, "enc actual");
    rchk(msprg_pkg::IDX_INST_VEL, 32'h5, "inst vel 1");
    rchk(msprg_pkg::IDX_AVG_VEL, 32'h5, "avg vel 1");
    wait_tick();
    rchk(msprg_pkg::IDX_INST_VEL, 32'h0, "inst vel 2");
    rchk(msprg_pkg::IDX_AVG_VEL, 32'h5, "avg vel 2");
    // loop period, single then doubled
    wait_tick();
    wait_tick();
    `CHK("period", LOOP, n)
    wb(1'b1, msprg_pkg::IDX_OUTDIV, 32'h2);
    wait_tick();
    wait_tick();
    wait_tick();
    `CHK("period x2", 2 * LOOP, n)
    stop_test();
  end
endmodule
